// ### core/vectored_irq_ctl.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "irq_consts.svh"
module vectored_irq_ctl (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Register port
   input wire logic [`REG_AW-1:0] i_reg_addr,
   input wire logic [`REG_DW-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [`REG_DW-1:0] o_reg_rdata,
   // Interrupt pins
   input wire logic i_nmi,
   input wire logic i_ext_irq_a,
   input wire logic i_ext_irq_b,
   input wire logic i_ext_irq_c,
   // Peripheral event pulses
   input wire logic i_timer_irq,
   input wire logic i_uart_irq,
   input wire logic i_end_of_message,
   input wire logic i_t0_overflow,
   // CPU core
   input wire logic i_instr_done,
   input wire logic i_return_from_interrupt,
   output logic o_entry,
   output logic o_push_pc,
   output logic o_pop_pc,
   output logic [`RANK_W-1:0] o_entry_rank,
   output logic [15:0] o_vector_addr,
   output logic [15:0] o_stack_addr,
   // DMA
   input wire logic i_dma_byte_busy,
   output logic o_dma_stop,
   // Power and pins
   output irq_pkg::mode_t o_mode,
   output logic o_cpu_stop,
   output logic o_clk_stop,
   output logic o_hdlc_uart_rst,
   output logic o_pins_hiz,
   output logic o_half_rate_clk
);
   import irq_pkg::*;

   logic rst_meta_q;
   logic rst_n;
   logic [`NUM_SRC-1:0] en_q;
   logic [`NUM_SRC-1:0] en_d;
   logic [`NUM_SRC-1:0] pend_q;
   logic [`NUM_SRC-1:0] pend_d;
   logic [`NUM_SRC-1:0] ev;
   logic [`NUM_SRC-1:0] mask;
   logic [`NUM_SRC-1:0] req;
   logic [`NUM_SRC-1:0] auto_clr;
   logic [2:0] edge_q;
   logic halt_en_q;
   logic [15:0] sp_q;
   logic [15:0] sp_d;
   mode_t mode_q;
   mode_t mode_d;
   logic [`RANK_W-1:0] rank;
   logic [`RANK_W-1:0] last_rank_q;
   logic take;
   logic nmi_active_q;
   logic dma_stop_q;
   logic pins_hiz_q;
   logic half_q;
   logic entry_q;
   logic push_q;
   logic pop_q;
   logic [`RANK_W-1:0] entry_rank_q;
   logic [15:0] vec_q;
   logic [15:0] stack_q;
   logic [`REG_DW-1:0] rdata_q;
   logic nmi_hit;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [`RANK_W-1:0] pick_rank(input logic [`NUM_SRC-1:0] r);
      logic [`RANK_W-1:0] k;
      k = '0;
      for (int i = `NUM_SRC - 1; i >= 0; i--) begin
         if (r[i]) begin
            k = `RANK_W'(i);
         end
      end
      return k;
   endfunction

   function automatic logic wr_hit(input logic [`REG_AW-1:0] a);
      return i_reg_wr && (i_reg_addr == a);
   endfunction

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // ----------------------------------------
   // Pin edge detection
   // ----------------------------------------
   pin_edge_if pins ();

   assign pins.raw = {i_ext_irq_c, i_ext_irq_b, i_ext_irq_a, i_nmi};
   assign pins.rise_sel = {edge_q, 1'b1};

   pin_edge_detect u_edges (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .pins(pins.det)
   );

   assign nmi_hit = pins.hit[0];

   // ----------------------------------------
   // Request gating and arbitration
   // ----------------------------------------
   always_comb begin
      ev = {i_end_of_message, i_uart_irq, i_timer_irq, pins.hit, 1'b0};
      mask = en_q & {`NUM_SRC{en_q[`GIE_BIT]}};
      mask[`SRC_RESET] = 1'b1;
      mask[`SRC_NMI] = ~i_dma_byte_busy;
      req = pend_q & mask;
      rank = pick_rank(req);
      take = (mode_q == MODE_RUN) && (req[`SRC_RESET] || (|req && i_instr_done));
      auto_clr = '0;
      if (take && (rank <= `RANK_W'(`SRC_EXT_C))) begin
         auto_clr[rank] = 1'b1;
      end
   end

   // ----------------------------------------
   // Pending flags
   // ----------------------------------------
   always_comb begin
      pend_d = wr_hit(`ADDR_PENDING) ? i_reg_wdata[`NUM_SRC-1:0] : pend_q;
      pend_d = (pend_d & ~(auto_clr & `AUTO_CLR_MASK)) | ev;
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= `PENDING_RST;
      end else begin
         pend_q <= pend_d;
      end
   end

   // ----------------------------------------
   // Enables and edge polarity
   // ----------------------------------------
   always_comb begin
      en_d = wr_hit(`ADDR_ENABLE) ? i_reg_wdata[`NUM_SRC-1:0] : en_q;
      if (take) begin
         en_d[`GIE_BIT] = 1'b0;
      end else if (i_return_from_interrupt) begin
         en_d[`GIE_BIT] = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= `ENABLE_RST;
      end else begin
         en_q <= en_d;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_q <= `EDGE_COND_RST;
      end else if (wr_hit(`ADDR_EDGE_COND)) begin
         edge_q <= i_reg_wdata[`SRC_EXT_C:`SRC_EXT_A];
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         halt_en_q <= 1'b0;
      end else if (wr_hit(`ADDR_HALT_EN)) begin
         halt_en_q <= i_reg_wdata[`HALT_EN_BIT];
      end
   end

   // ----------------------------------------
   // Stack pointer
   // ----------------------------------------
   always_comb begin
      sp_d = wr_hit(`ADDR_STACK_PTR) ? i_reg_wdata : sp_q;
      if (take && (rank != `RANK_W'(`SRC_RESET))) begin
         sp_d = sp_q + `SP_STEP;
      end else if (i_return_from_interrupt) begin
         sp_d = sp_q - `SP_STEP;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_q <= `STACK_PTR_RST;
      end else begin
         sp_q <= sp_d;
      end
   end

   // ----------------------------------------
   // Entry and return strobes
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         entry_q <= 1'b0;
         push_q <= 1'b0;
         pop_q <= 1'b0;
         entry_rank_q <= '0;
         vec_q <= `VEC_TOP;
         stack_q <= `STACK_PTR_RST;
      end else begin
         entry_q <= take;
         push_q <= take && (rank != `RANK_W'(`SRC_RESET));
         pop_q <= i_return_from_interrupt && !take;
         if (take) begin
            entry_rank_q <= rank;
            vec_q <= `VEC_TOP - {12'h0000, rank, 1'b0};
            stack_q <= sp_q;
         end else if (i_return_from_interrupt) begin
            stack_q <= sp_q - `SP_STEP;
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_rank_q <= '0;
      end else if (take) begin
         last_rank_q <= rank;
      end
   end

   // ----------------------------------------
   // DMA stop on non-maskable
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         nmi_active_q <= 1'b0;
         dma_stop_q <= 1'b0;
      end else begin
         if (take && (rank == `RANK_W'(`SRC_NMI))) begin
            nmi_active_q <= 1'b1;
         end else if (i_return_from_interrupt) begin
            nmi_active_q <= 1'b0;
         end
         if (nmi_hit) begin
            dma_stop_q <= 1'b1;
         end else if (i_return_from_interrupt && nmi_active_q) begin
            dma_stop_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Power-save modes
   // ----------------------------------------
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         MODE_RUN: begin
            if (wr_hit(`ADDR_PSW) && i_reg_wdata[`PSW_HALT_BIT] && halt_en_q) begin
               mode_d = MODE_HALT;
            end else if (wr_hit(`ADDR_PSW) && i_reg_wdata[`PSW_IDLE_BIT]) begin
               mode_d = MODE_IDLE;
            end
         end
         MODE_HALT: begin
            if (nmi_hit) begin
               mode_d = MODE_RUN;
            end
         end
         MODE_IDLE: begin
            if (nmi_hit || i_t0_overflow) begin
               mode_d = MODE_RUN;
            end
         end
         default: begin
            mode_d = MODE_RUN;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_hdlc_uart_rst <= 1'b0;
      end else begin
         o_hdlc_uart_rst <= (mode_q == MODE_RUN) && (mode_d != MODE_RUN);
      end
   end

   // ----------------------------------------
   // Pin float and clock divider
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_hiz_q <= 1'b1;
      end else if (take && (rank == `RANK_W'(`SRC_RESET))) begin
         pins_hiz_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         half_q <= 1'b0;
      end else if (mode_q != MODE_HALT) begin
         half_q <= ~half_q;
      end
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            `ADDR_ENABLE: rdata_q <= {8'h00, en_q};
            `ADDR_PENDING: rdata_q <= {8'h00, pend_q};
            `ADDR_EDGE_COND: rdata_q <= {11'h000, edge_q, 2'h0};
            `ADDR_PSW: rdata_q <= {14'h0000, mode_q == MODE_IDLE, mode_q == MODE_HALT};
            `ADDR_HALT_EN: rdata_q <= {15'h0000, halt_en_q};
            `ADDR_STACK_PTR: rdata_q <= sp_q;
            `ADDR_STATUS: rdata_q <= {10'h000, dma_stop_q, nmi_active_q, |req, last_rank_q};
            default: rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_reg_rdata = rdata_q;
   assign o_entry = entry_q;
   assign o_push_pc = push_q;
   assign o_pop_pc = pop_q;
   assign o_entry_rank = entry_rank_q;
   assign o_vector_addr = vec_q;
   assign o_stack_addr = stack_q;
   assign o_dma_stop = dma_stop_q;
   assign o_mode = mode_q;
   assign o_cpu_stop = (mode_q != MODE_RUN);
   assign o_clk_stop = (mode_q == MODE_HALT);
   assign o_pins_hiz = pins_hiz_q;
   assign o_half_rate_clk = half_q;
endmodule

// ### core/irq_consts.svh
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// ----------------------------------------
// Register port
// ----------------------------------------
`define REG_AW 3
`define REG_DW 16
`define ADDR_ENABLE 3'h0
`define ADDR_PENDING 3'h1
`define ADDR_EDGE_COND 3'h2
`define ADDR_PSW 3'h3
`define ADDR_HALT_EN 3'h4
`define ADDR_STACK_PTR 3'h5
`define ADDR_STATUS 3'h6

// ----------------------------------------
// Sources and ranks
// ----------------------------------------
`define NUM_SRC 8
`define RANK_W 3
`define SRC_RESET 0
`define SRC_NMI 1
`define SRC_EXT_A 2
`define SRC_EXT_C 4
`define SRC_TIMER 5
`define SRC_UART 6
`define SRC_EOM 7
`define NUM_PINS 4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GIE_BIT 0
`define PSW_HALT_BIT 0
`define PSW_IDLE_BIT 1
`define HALT_EN_BIT 0

// ----------------------------------------
// Reset values and vectors
// ----------------------------------------
`define ENABLE_RST 8'h00
`define PENDING_RST 8'h01
`define EDGE_COND_RST 3'h0
`define STACK_PTR_RST 16'h0000
`define VEC_TOP 16'hFFFE
`define SP_STEP 16'h0002
`define AUTO_CLR_MASK 8'h1F
`define PRIME_W 3

`endif

// ### core/irq_pkg.sv
package irq_pkg;
   // Power state of the core
   typedef enum logic [1:0] {MODE_RUN, MODE_HALT, MODE_IDLE} mode_t;
endpackage

// ### core/pin_edge_if.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
interface pin_edge_if;
   logic [`NUM_PINS-1:0] raw;
   logic [`NUM_PINS-1:0] rise_sel;
   logic [`NUM_PINS-1:0] hit;
   modport det (input raw, input rise_sel, output hit);
   modport ctl (output raw, output rise_sel, input hit);
endinterface

// ### core/pin_edge_detect.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
module pin_edge_detect (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Pins and edge pulses
   pin_edge_if.det pins
);
   logic [`NUM_PINS-1:0] meta_q;
   logic [`NUM_PINS-1:0] sync_q;
   logic [`NUM_PINS-1:0] prev_q;
   logic [`PRIME_W-1:0] prime_q;

   // ----------------------------------------
   // Synchronisers and edge compare
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
         prime_q <= '0;
      end else begin
         meta_q <= pins.raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
         prime_q <= {prime_q[`PRIME_W-2:0], 1'b1};
      end
   end

   genvar g;
   generate
      for (g = 0; g < `NUM_PINS; g++) begin : g_pin
         // Selected edge, only once the history is valid
         assign pins.hit[g] = prime_q[`PRIME_W-1] &
            (pins.rise_sel[g] ? (sync_q[g] & ~prev_q[g]) : (~sync_q[g] & prev_q[g]));
      end
   endgenerate
endmodule

// ### bench/cpu_side_model.sv
`timescale 1ns/1ps
module cpu_side_model (
   // Clock
   input wire logic i_clk,
   // Bench controls
   input wire logic i_slow,
   input wire logic i_busy_req,
   // Towards the controller
   output logic o_instr_done,
   output logic o_dma_byte_busy
);
   logic [1:0] cnt_q = 2'h0;
   // Instruction end every cycle, or every fourth when slow
   always_ff @(posedge i_clk) begin
      cnt_q <= cnt_q + 2'h1;
      o_instr_done <= !i_slow || (cnt_q == 2'h3);
   end
   // Byte transfer in progress
   always_ff @(posedge i_clk) begin
      o_dma_byte_busy <= i_busy_req;
   end
endmodule

// ### bench/vectored_irq_ctl_chk.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
module vectored_irq_ctl_chk (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Core and events
   input wire logic i_instr_done,
   input wire logic i_return_from_interrupt,
   input wire logic i_dma_byte_busy,
   input wire logic i_t0_overflow,
   // Entry and return
   input wire logic o_entry,
   input wire logic o_push_pc,
   input wire logic o_pop_pc,
   input wire logic [`RANK_W-1:0] o_entry_rank,
   input wire logic [15:0] o_vector_addr,
   // Power and pins
   input wire logic o_dma_stop,
   input irq_pkg::mode_t o_mode,
   input wire logic o_cpu_stop,
   input wire logic o_clk_stop,
   input wire logic o_hdlc_uart_rst,
   input wire logic o_pins_hiz,
   input wire logic o_half_rate_clk
);
   import irq_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   AST_VEC_MAP: assert property (o_entry |-> o_vector_addr == 16'hFFFE - {12'h000, o_entry_rank, 1'b0})
      else $error("vector does not match rank");
   AST_HIZ_END: assert property ($fell(o_pins_hiz) |-> o_entry && o_entry_rank == 3'h0)
      else $error("pins left high impedance without reset entry");
   AST_INSTR_END: assert property (o_entry && o_entry_rank != 3'h0 |-> $past(i_instr_done))
      else $error("entry before instruction end");
   AST_PUSH: assert property (o_entry |-> o_push_pc == (o_entry_rank != 3'h0))
      else $error("push does not match entry");
   AST_POP: assert property (o_pop_pc |-> $past(i_return_from_interrupt))
      else $error("pop without return");
   AST_DMA_HOLD: assert property (o_entry && o_entry_rank == 3'h1 |-> !$past(i_dma_byte_busy))
      else $error("nmi entry during byte transfer");
   AST_DMA_STOP: assert property (o_entry && o_entry_rank == 3'h1 |-> o_dma_stop)
      else $error("dma still running at nmi entry");
   AST_RUN_ONLY: assert property (o_entry |-> $past(o_mode) == MODE_RUN)
      else $error("entry outside run mode");
   AST_STOPS: assert property (o_clk_stop == (o_mode == MODE_HALT) && o_cpu_stop == (o_mode != MODE_RUN))
      else $error("stop outputs do not match mode");
   AST_FREEZE: assert property (o_mode == MODE_HALT && $past(o_mode) == MODE_HALT |-> $stable(o_half_rate_clk))
      else $error("half rate clock runs in halt");
   AST_PS_RST: assert property ($rose(o_cpu_stop) |-> o_hdlc_uart_rst)
      else $error("no channel reset on power save entry");
   AST_IDLE_WAKE: assert property (o_mode == MODE_IDLE && i_t0_overflow |=> o_mode == MODE_RUN)
      else $error("idle not left on timer overflow");
   AST_WAKE_CAUSE: assert property ($past(o_mode) == MODE_HALT && o_mode == MODE_RUN |->
      ##[0:12] o_entry && o_entry_rank == 3'h1)
      else $error("halt left without nmi entry");
   AST_HALF_RUN: assert property ($past(i_arst_n) && $past(o_mode) != MODE_HALT |->
      o_half_rate_clk != $past(o_half_rate_clk))
      else $error("half rate clock stopped outside halt");
endmodule
bind vectored_irq_ctl vectored_irq_ctl_chk chk (.i_clk, .i_arst_n, .i_instr_done, .i_return_from_interrupt, .i_dma_byte_busy,
   .i_t0_overflow, .o_entry, .o_push_pc, .o_pop_pc, .o_entry_rank, .o_vector_addr, .o_dma_stop, .o_mode,
   .o_cpu_stop, .o_clk_stop, .o_hdlc_uart_rst, .o_pins_hiz, .o_half_rate_clk);

// ### bench/vectored_irq_ctl_tb_top.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
module vectored_irq_ctl_tb_top;
   import irq_pkg::*;
   typedef struct packed {logic [15:0] v; logic [15:0] s;} ev_t;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [2:0] i_reg_addr = 3'h0;
   logic [15:0] i_reg_wdata = 16'h0000;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic i_nmi = 1'b0;
   logic i_ext_irq_a = 1'b0;
   logic i_ext_irq_b = 1'b1;
   logic i_ext_irq_c = 1'b0;
   logic i_timer_irq = 1'b0;
   logic i_uart_irq = 1'b0;
   logic i_end_of_message = 1'b0;
   logic i_t0_overflow = 1'b0;
   logic i_return_from_interrupt = 1'b0;
   logic slow = 1'b0;
   logic busy_req = 1'b0;
   logic rd_seen = 1'b0;
   logic i_instr_done, i_dma_byte_busy, o_entry, o_push_pc, o_pop_pc, o_dma_stop;
   logic o_cpu_stop, o_clk_stop, o_hdlc_uart_rst, o_pins_hiz, o_half_rate_clk;
   logic [15:0] o_reg_rdata, o_vector_addr, o_stack_addr;
   logic [2:0] o_entry_rank;
   mode_t o_mode;
   logic [31:0] lfsr = 32'h0000_c325;
   int errors = 0;
   int tests_run = 0;
   ev_t evq[$];
   ev_t e;
   logic [15:0] rdq[$];
   always #50 i_clk = ~i_clk;
   cpu_side_model cpu (.i_clk, .i_slow(slow), .i_busy_req(busy_req), .o_instr_done(i_instr_done),
      .o_dma_byte_busy(i_dma_byte_busy));
   vectored_irq_ctl dut (.i_clk, .i_arst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
      .i_nmi, .i_ext_irq_a, .i_ext_irq_b, .i_ext_irq_c, .i_timer_irq, .i_uart_irq, .i_end_of_message,
      .i_t0_overflow, .i_instr_done, .i_return_from_interrupt, .o_entry, .o_push_pc, .o_pop_pc, .o_entry_rank, .o_vector_addr,
      .o_stack_addr, .i_dma_byte_busy, .o_dma_stop, .o_mode, .o_cpu_stop, .o_clk_stop, .o_hdlc_uart_rst,
      .o_pins_hiz, .o_half_rate_clk);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic cmp_rd(input logic [15:0] x, input logic [15:0] g);
      tests_run++;
      if (g !== x) begin
         errors++;
         $display("MISMATCH reg_read exp %h got %h", x, g);
      end
   endtask
   task automatic cmp_ev(input string n, input logic [15:0] x, input logic [15:0] g);
      tests_run++;
      if (g !== x) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", n, x, g);
      end
   endtask
   task automatic cm(input mode_t m);
      cmp_ev("mode", {14'h0000, m}, {14'h0000, o_mode});
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] x);
      rdq.push_back(x);
      @(posedge i_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
   endtask
   task automatic ex(input logic [15:0] v, input logic [15:0] s);
      evq.push_back({v, s});
   endtask
   task automatic wt;
      int n;
      n = 0;
      while (evq.size() != 0 && n < 300) begin
         @(posedge i_clk);
         n++;
      end
      if (evq.size() != 0) begin
         errors++;
         $display("MISMATCH event exp %h got none", evq[0].v);
         evq.delete();
      end
   endtask
   task automatic rt;
      @(posedge i_clk);
      i_return_from_interrupt <= 1'b1;
      @(posedge i_clk);
      i_return_from_interrupt <= 1'b0;
   endtask
   task automatic tp;
      @(posedge i_clk);
      i_t0_overflow <= 1'b1;
      @(posedge i_clk);
      i_t0_overflow <= 1'b0;
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Monitor
   // ----------------------------------------
   always @(posedge i_clk) begin
      rd_seen <= i_reg_rd;
   end
   always @(negedge i_clk) begin
      if (rd_seen) begin
         cmp_rd(rdq.pop_front(), o_reg_rdata);
      end
      if (o_entry === 1'b1 || o_pop_pc === 1'b1) begin
         if (evq.size() == 0) begin
            errors++;
            $display("MISMATCH event exp none got %h", o_vector_addr);
         end else begin
            e = evq.pop_front();
            cmp_ev("vector", e.v, o_pop_pc ? 16'h0000 : o_vector_addr);
            cmp_ev("stack", e.s, o_stack_addr);
         end
      end
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      errors++;
      $display("MISMATCH watchdog exp finish got timeout");
      close_out;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (40) @(posedge i_clk);
      cmp_ev("pins_hiz", 16'h0001, {15'h0000, o_pins_hiz});
      ex(`VEC_TOP, 16'h0000);
      i_arst_n <= 1'b1;
      wt;
      cmp_ev("pins_hiz", 16'h0000, {15'h0000, o_pins_hiz});
      rd(3'h0, 16'h0000);
      rd(3'h1, 16'h0000);
      lfsr = nx(lfsr);
      wr(3'h7, lfsr[15:0]);
      rd(3'h7, 16'h0000);
      $display("reset test done");
      @(posedge i_clk);
      i_timer_irq <= 1'b1;
      i_uart_irq <= 1'b1;
      i_end_of_message <= 1'b1;
      @(posedge i_clk);
      i_timer_irq <= 1'b0;
      i_uart_irq <= 1'b0;
      i_end_of_message <= 1'b0;
      repeat (3) @(posedge i_clk);
      rd(3'h1, 16'h00E0);
      ex(16'hFFF4, 16'h0000);
      wr(3'h0, 16'h00E1);
      wt;
      rd(3'h0, 16'h00E0);
      rd(3'h1, 16'h00E0);
      rd(3'h5, 16'h0002);
      wr(3'h1, 16'h0000);
      ex(16'h0000, 16'h0000);
      rt;
      wt;
      rd(3'h0, 16'h00E1);
      $display("peripheral test done");
      wr(3'h2, 16'h0014);
      rd(3'h2, 16'h0014);
      wr(3'h0, 16'h001D);
      lfsr = nx(lfsr);
      repeat (lfsr[2:0]) @(posedge i_clk);
      @(posedge i_clk);
      i_ext_irq_a <= 1'b1;
      i_ext_irq_b <= 1'b0;
      i_ext_irq_c <= 1'b1;
      ex(16'hFFFA, 16'h0000);
      wt;
      rd(3'h1, 16'h0018);
      for (int i = 1; i < 3; i++) begin
         ex(16'hFFFA - 16'(2 * i), 16'(2 * i));
         wr(3'h0, 16'h001D);
         wt;
      end
      rd(3'h1, 16'h0000);
      for (int i = 2; i >= 0; i--) begin
         ex(16'h0000, 16'(2 * i));
         rt;
         wt;
      end
      @(posedge i_clk);
      i_ext_irq_a <= 1'b0;
      i_ext_irq_b <= 1'b1;
      i_ext_irq_c <= 1'b0;
      repeat (6) @(posedge i_clk);
      rd(3'h1, 16'h0000);
      $display("external pin test done");
      wr(3'h0, 16'h0000);
      slow <= 1'b1;
      busy_req <= 1'b1;
      @(posedge i_clk);
      i_nmi <= 1'b1;
      repeat (12) @(posedge i_clk);
      cmp_ev("dma_stop", 16'h0001, {15'h0000, o_dma_stop});
      ex(16'hFFFC, 16'h0000);
      busy_req <= 1'b0;
      wt;
      rd(3'h6, 16'h0031);
      ex(16'h0000, 16'h0000);
      rt;
      wt;
      cmp_ev("dma_stop", 16'h0000, {15'h0000, o_dma_stop});
      slow <= 1'b0;
      i_nmi <= 1'b0;
      $display("nmi test done");
      wr(3'h3, 16'h0001);
      repeat (2) @(posedge i_clk);
      cm(MODE_RUN);
      wr(3'h4, 16'h0001);
      wr(3'h3, 16'h0001);
      repeat (2) @(posedge i_clk);
      cm(MODE_HALT);
      rd(3'h3, 16'h0001);
      tp;
      repeat (3) @(posedge i_clk);
      cm(MODE_HALT);
      ex(16'hFFFC, 16'h0000);
      i_nmi <= 1'b1;
      wt;
      cm(MODE_RUN);
      ex(16'h0000, 16'h0000);
      rt;
      wt;
      i_nmi <= 1'b0;
      wr(3'h3, 16'h0002);
      repeat (2) @(posedge i_clk);
      cm(MODE_IDLE);
      tp;
      repeat (2) @(posedge i_clk);
      cm(MODE_RUN);
      $display("power test done");
      wr(3'h3, 16'h0001);
      repeat (2) @(posedge i_clk);
      cm(MODE_HALT);
      i_arst_n <= 1'b0;
      repeat (40) @(posedge i_clk);
      cm(MODE_RUN);
      cmp_ev("pins_hiz", 16'h0001, {15'h0000, o_pins_hiz});
      ex(`VEC_TOP, 16'h0000);
      i_arst_n <= 1'b1;
      wt;
      cmp_ev("pins_hiz", 16'h0000, {15'h0000, o_pins_hiz});
      rd(3'h4, 16'h0000);
      $display("halt reset test done");
      close_out;
   end
endmodule
